// ---- inc/wdg_defs.svh ----
// wdg_defs.svh: timing counts and pin-mode codes for the watchdog block
// assumes: included by package and design files, clock rate 200 MHz
`ifndef WDG_DEFS_SVH
`define WDG_DEFS_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define WDG_CLK_MHZ        200
`define WDG_ACTIVATION_OUTPUT_FALL_NS  200
// longest time: rounds down
`define WDG_ACTIVATION_OUTPUT_FALL_CYC ((`WDG_ACTIVATION_OUTPUT_FALL_NS * `WDG_CLK_MHZ) / 1000)
// reset pulse and deadlines in cycles (documented tables lie elsewhere)
`define WDG_RST_CYC        200000
`define WDG_DL_PRESET_A    1000000
`define WDG_DL_PRESET_B    2000000
`define WDG_DL_CAP_UNIT    100
`define WDG_CNT_W          32

// ----------------------------------------------------------------
// timing pin modes
// ----------------------------------------------------------------
`define WDG_CAP_CAP        2'h0
`define WDG_CAP_PULLUP     2'h1
`define WDG_CAP_OPEN       2'h2

// synchroniser reset: enabled, kick high, select high, open timing pin
`define WDG_SYNC_RST       5'h17

`endif

// ---- inc/wdg_pkg.sv ----
// wdg_pkg.sv: types shared by the watchdog block
// assumes: wdg_defs.svh on the include path
`include "wdg_defs.svh"
package wdg_pkg;
  typedef enum logic [1:0] {
    WDG_OFF   = 2'b00,  // activation input low
    WDG_DELAY = 2'b01,  // waiting out reset pulse after enable
    WDG_RUN   = 2'b10,  // counting toward deadline
    WDG_BARK  = 2'b11   // timeout reset output asserted
  } wdg_state_e;
  typedef logic [`WDG_CNT_W-1:0] wdg_cnt_t;
endpackage : wdg_pkg

// ---- inc/wdg_sync_if.sv ----
// wdg_sync_if.sv: synchronised pin levels passed to the core
// assumes: driven by wdg_sync, read by wdg_top
interface wdg_sync_if;
  logic       act;     // activation input
  logic       kick;    // kick input
  logic       sel;     // timeout select pin
  logic [1:0] cap;     // timing pin mode
  modport src (output act, output kick, output sel, output cap);
  modport dst (input  act, input  kick, input  sel, input  cap);
endinterface : wdg_sync_if

// ---- hdl/wdg_sync.sv ----
// wdg_sync.sv: two-flop synchronisers for all asynchronous pins except the capacitor code
// assumes: single clock clk, synchronous active-high rst
`include "wdg_defs.svh"
module wdg_sync #(
  parameter int W = 5           // pins synchronised
) (
  input  wire logic         clk,   // system clock
  input  wire logic         rst,   // synchronous reset
  input  wire logic [W-1:0] pin,   // raw pin levels
  wdg_sync_if.src           so     // synchronised levels
);
  logic [W-1:0] s1_r, s1_nxt;
  logic [W-1:0] s2_r, s2_nxt;

  // ----------------------------------------------------------------
  // first and second stage; first read only by second
  // ----------------------------------------------------------------
  initial begin
    if (W != 5) $error("wdg_sync: W must be 5");
  end

  always_comb begin
    s1_nxt = pin;
    s2_nxt = s1_r;
  end

  // reset to enable high, kick high, select high, open timing pin
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= W'(`WDG_SYNC_RST);
      s2_r <= W'(`WDG_SYNC_RST);
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  assign so.act  = s2_r[0];
  assign so.kick = s2_r[1];
  assign so.sel  = s2_r[2];
  assign so.cap  = s2_r[4:3];
endmodule : wdg_sync

// ---- hdl/wdg_top.sv ----
// wdg_top.sv: standalone watchdog supervisor with activation control
// assumes: pins are asynchronous, 200 MHz clock, sync active-high reset
`include "wdg_defs.svh"

module wdg_top #(
  parameter int RST_CYC  = `WDG_RST_CYC,      // reset pulse length
  parameter int DL_A     = `WDG_DL_PRESET_A,  // preset, pull-up
  parameter int DL_B     = `WDG_DL_PRESET_B,  // preset, open pin
  parameter int CAP_UNIT = `WDG_DL_CAP_UNIT   // cycles per cap code
) (
  input  wire logic       clk,           // 200 MHz clock
  input  wire logic       rst,           // sync reset, active high
  input  wire logic       activation_in, // enable input pin
  input  wire logic       kick_input,    // watchdog kick pin
  input  wire logic       timeout_select_pin, // low disables timer
  input  wire logic [1:0] timing_cap_pin,     // timing pin mode
  input  wire logic [15:0] cap_code,     // capacitor size code
  output logic            activation_output,  // delayed enable
  output logic            timeout_reset_n     // active-low reset out
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (RST_CYC < 1 || DL_A < 1 || DL_B < 1 || CAP_UNIT < 1)
      $error("wdg_top: counts must be at least one");
    if (`WDG_ACTIVATION_OUTPUT_FALL_CYC < 3)
      $error("wdg_top: synchroniser exceeds activation fall bound");
    if (64'(CAP_UNIT) * 64'h0000_0000_0001_0000 > 64'h0000_0000_ffff_ffff)
      $error("wdg_top: capacitor deadline overflows the counter");
  end

  wdg_sync_if sif ();

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wdg_sync #(.W(5)) u_sync (
    .clk (clk),
    .rst (rst),
    .pin ({timing_cap_pin, timeout_select_pin, kick_input,
           activation_in}),
    .so  (sif)
  );

  wdg_pkg::wdg_state_e st_r, st_nxt;
  wdg_pkg::wdg_cnt_t   cnt_r, cnt_nxt;
  wdg_pkg::wdg_cnt_t   deadline;
  logic                kick_d_r, kick_d_nxt;
  logic                act_out_r, act_out_nxt;
  logic                wdo_n_r, wdo_n_nxt;
  logic                kick_fall;
  logic                disabled;
  logic [15:0]         code_s1_r, code_s1_nxt;
  logic [15:0]         code_s2_r, code_s2_nxt;
  logic [15:0]         code_s3_r, code_s3_nxt;
  logic [15:0]         cfg_code_r, cfg_code_nxt;
  logic [1:0]          mode_p_r, mode_p_nxt;
  logic [1:0]          cfg_mode_r, cfg_mode_nxt;

  // ----------------------------------------------------------------
  // strap filtering
  // ----------------------------------------------------------------
  // the capacitor code is a pin word: two flops, then a third stage;
  // a value is taken only once two samples agree, so a skewed change
  // of several bits never selects a wrong deadline for one cycle
  always_comb begin
    code_s1_nxt  = cap_code;
    code_s2_nxt  = code_s1_r;
    code_s3_nxt  = code_s2_r;
    mode_p_nxt   = sif.cap;
    cfg_code_nxt = cfg_code_r;
    cfg_mode_nxt = cfg_mode_r;
    if (code_s2_r == code_s3_r) begin
      cfg_code_nxt = code_s3_r;
    end
    // timing pin mode gets the same two-sample agreement
    if (sif.cap == mode_p_r) begin
      cfg_mode_nxt = mode_p_r;
    end
  end

  // strap registers only
  always_ff @(posedge clk) begin
    if (rst) begin
      code_s1_r  <= '0;
      code_s2_r  <= '0;
      code_s3_r  <= '0;
      cfg_code_r <= '0;
      mode_p_r   <= `WDG_CAP_OPEN;
      cfg_mode_r <= `WDG_CAP_OPEN;
    end else begin
      code_s1_r  <= code_s1_nxt;
      code_s2_r  <= code_s2_nxt;
      code_s3_r  <= code_s3_nxt;
      cfg_code_r <= cfg_code_nxt;
      mode_p_r   <= mode_p_nxt;
      cfg_mode_r <= cfg_mode_nxt;
    end
  end

  // ----------------------------------------------------------------
  // deadline selection
  // ----------------------------------------------------------------
  // capacitor mode and the unused code 3 scale the code; presets otherwise
  always_comb begin
    unique case (cfg_mode_r)
      `WDG_CAP_PULLUP: deadline = wdg_pkg::wdg_cnt_t'(DL_A);
      `WDG_CAP_OPEN:   deadline = wdg_pkg::wdg_cnt_t'(DL_B);
      default:         deadline = wdg_pkg::wdg_cnt_t'(
                         (cfg_code_r + 32'h1) * CAP_UNIT);
    endcase
  end

  assign disabled  = !sif.sel;
  assign kick_fall = kick_d_r && !sif.kick;

  // ----------------------------------------------------------------
  // watchdog sequencer
  // ----------------------------------------------------------------
  // off:   activation low; outputs forced, counter cleared
  // delay: activation back; counter times the release delay
  // run:   counter climbs toward the deadline; a kick edge
  //        clears it, a low select pin holds it at zero
  // bark:  reset output low; counter times the pulse, kicks
  //        are not looked at until it ends
  // the activation pin is tested ahead of the state, so a
  // low level wins in every state, a running pulse included
  // one counter serves all three timed states; it is cleared
  // on every change of state so no count leaks across
  // trade-off: the kick edge is taken from the synchronised
  // level, so a kick needs one cycle per level to be seen
  // limitation: deadline and pulse counts are in clock cycles;
  // oscillator tolerance is not modelled, counts are exact
  // presets and pulse length are plain parameters to be set
  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    kick_d_nxt  = sif.kick;
    act_out_nxt = act_out_r;
    wdo_n_nxt   = wdo_n_r;
    if (!sif.act) begin
      // activation low overrides everything, checked first
      st_nxt      = wdg_pkg::WDG_OFF;
      cnt_nxt     = '0;
      act_out_nxt = 1'b0;
      wdo_n_nxt   = 1'b1;
    end else begin
      unique case (st_r)
        wdg_pkg::WDG_OFF: begin
          st_nxt  = wdg_pkg::WDG_DELAY;
          cnt_nxt = '0;
        end
        wdg_pkg::WDG_DELAY: begin
          // counter reused for the release delay
          if (cnt_r >= wdg_pkg::wdg_cnt_t'(RST_CYC - 1)) begin
            st_nxt      = wdg_pkg::WDG_RUN;
            cnt_nxt     = '0;
            act_out_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
        wdg_pkg::WDG_RUN: begin
          if (disabled) begin
            cnt_nxt = '0;
          end else if (kick_fall) begin
            cnt_nxt = '0;
          end else if (cnt_r >= deadline - 1'b1) begin
            st_nxt    = wdg_pkg::WDG_BARK;
            cnt_nxt   = '0;
            wdo_n_nxt = 1'b0;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
        wdg_pkg::WDG_BARK: begin
          // kicks ignored here
          if (cnt_r >= wdg_pkg::wdg_cnt_t'(RST_CYC - 1)) begin
            st_nxt    = wdg_pkg::WDG_RUN;
            cnt_nxt   = '0;
            wdo_n_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
      endcase
    end
  end

  // state registers only
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r      <= wdg_pkg::WDG_OFF;
      cnt_r     <= '0;
      kick_d_r  <= 1'b1;
      act_out_r <= 1'b0;
      wdo_n_r   <= 1'b1;
    end else begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      kick_d_r  <= kick_d_nxt;
      act_out_r <= act_out_nxt;
      wdo_n_r   <= wdo_n_nxt;
    end
  end

  assign activation_output = act_out_r;
  assign timeout_reset_n   = wdo_n_r;
endmodule : wdg_top

// ---- verification/wdg_properties.sv ----
// wdg_properties.sv: pin timing checks for the watchdog
// assumes: bound into wdg_top, one clock, sync reset
module wdg_properties #(
  parameter int RST_CYC = 20, DL_A = 50, DL_B = 80, CAP_UNIT = 2
) (
  input wire logic        clk,                // clock
  input wire logic        rst,                // reset
  input wire logic        activation_in,      // enable
  input wire logic        kick_input,         // kick
  input wire logic        timeout_select_pin, // select
  input wire logic [1:0]  timing_cap_pin,     // mode
  input wire logic [15:0] cap_code,           // cap
  input wire logic        activation_output,  // enable out
  input wire logic        timeout_reset_n     // reset out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  int lo_r, hi_r, quiet_r, dl;
  // run lengths; sync lag widens the deadline band
  always_ff @(posedge clk) begin
    lo_r <= (rst || timeout_reset_n) ? 0 : lo_r + 1;
    hi_r <= (rst || !activation_in) ? 0 : hi_r + 1;
    quiet_r <= (rst || !activation_output || !timeout_reset_n ||
      !timeout_select_pin || $fell(kick_input)) ? 0 : quiet_r + 1;
  end
  always_comb dl = timing_cap_pin == 2'h1 ? DL_A : timing_cap_pin == 2'h2 ?
    DL_B : (int'(cap_code) + 1) * CAP_UNIT;
  sequence s_bark;
    $fell(timeout_reset_n);
  endsequence
  a_fall_fast: assert property ($fell(activation_in) |->
    ##[1:40] !activation_output) else $error("slow fall");
  a_off_quiet: assert property (!activation_in [*8] |->
    !activation_output && timeout_reset_n) else $error("busy when off");
  a_pulse_len: assert property ($rose(timeout_reset_n) |->
    lo_r == RST_CYC) else $error("pulse length");
  a_pulse_held: assert property (!timeout_reset_n &&
    lo_r < RST_CYC - 1 |=> !timeout_reset_n) else $error("pulse cut short");
  a_sel_off: assert property (!timeout_select_pin [*4] ##0
    timeout_reset_n |=> timeout_reset_n) else $error("timeout when off");
  a_rise_delay: assert property ($rose(activation_output) |->
    hi_r >= RST_CYC && hi_r <= RST_CYC + 6) else $error("rise timing");
  a_deadline: assert property (s_bark |-> quiet_r >= dl
    && quiet_r <= dl + 8) else $error("timeout count");
  a_run_first: assert property (s_bark |->
    $past(activation_output, 2)) else $error("timeout before release");
endmodule : wdg_properties
bind wdg_top wdg_properties #(.RST_CYC(RST_CYC), .DL_A(DL_A), .DL_B(DL_B),
  .CAP_UNIT(CAP_UNIT)) wdg_properties_i (.clk, .rst, .activation_in,
  .kick_input, .timeout_select_pin, .timing_cap_pin, .cap_code,
  .activation_output, .timeout_reset_n);

// ---- verification/wdg_host_model.sv ----
// wdg_host_model.sv: supervised processor strobing the kick pin
// assumes: bench sets kicking and half between clock edges
module wdg_host_model (
  input  wire logic       clk,       // clock
  input  wire logic       kicking,   // strobe on
  input  wire logic [7:0] half,      // cycles per level
  output logic            kick_input // kick pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt_r = 8'h00;
  // idle holds the last level so the pin never floats
  initial kick_input = 1'b1;
  always @(posedge clk) begin
    cnt_r <= (kicking && cnt_r + 8'h01 < half) ? cnt_r + 8'h01 : 8'h00;
    if (kicking && cnt_r + 8'h01 >= half) kick_input <= ~kick_input;
  end
endmodule : wdg_host_model

// ---- verification/tb_wdg_top.sv ----
// tb_wdg_top.sv: random and corner runs of wdg_top
// assumes: short counts below; host model kicks
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %0t %h %h", $time, g, e); end end
module tb_wdg_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RC = 20, DA = 50, DB = 80, CU = 2;
  logic        clk = 0, rst = 1, act = 1, sel = 1, kicking = 1;
  logic [1:0]  mode = 2'h1;
  logic [15:0] code = 16'h0008;
  logic [7:0]  half = 8'h02;
  logic        kick, en_out, rst_out_n;
  logic [31:0] seed = 32'hc48c1db7;
  int          fails = 0, n_checks = 0, n, e, barks = 0, b0;
  always #2.5 clk = ~clk;
  always @(negedge rst_out_n) barks++;
  wdg_host_model wdg_host_model_i (.clk, .kicking, .half, .kick_input(kick));
  wdg_top #(.RST_CYC(RC), .DL_A(DA), .DL_B(DB), .CAP_UNIT(CU)) wdg_top_i (
    .clk, .rst, .activation_in(act), .kick_input(kick),
    .timeout_select_pin(sel), .timing_cap_pin(mode), .cap_code(code),
    .activation_output(en_out), .timeout_reset_n(rst_out_n));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int exp_dl(logic [1:0] m, logic [15:0] c);
    return m == 2'h1 ? DA : m == 2'h2 ? DB : (int'(c) + 1) * CU;
  endfunction : exp_dl
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // bounded wait for a pin level; a hang ends the run
  task automatic wait_pin(logic pick, logic lvl, int lim);
    for (n = 0; (pick ? rst_out_n : en_out) !== lvl; n++) begin
      if (n == lim) fails++;
      if (n == lim) give_verdict();
      @(negedge clk);
    end
  endtask : wait_pin
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk);
    rst = 0;
    wait_pin(0, 1, RC + 10);
    for (int m = 0; m < 4; m++) begin
      mode = m[1:0];
      code = 16'(rnd() % 8 + 8);
      half = 8'(rnd() % 3 + 2);
      b0 = barks;
      repeat (150) @(negedge clk);
      `CHK(barks, b0)
      kicking = 0;
      e = exp_dl(mode, code);
      wait_pin(1, 0, e + 20);
      `CHK(n >= e - 8 && n <= e + 8, 1'b1)
      kicking = 1; // kicks inside the pulse must not shorten it
      wait_pin(1, 1, RC + 5);
      `CHK(n, RC)
    end
    kicking = 0;
    sel = 0;
    b0 = barks;
    repeat (200) @(negedge clk);
    `CHK(barks, b0)
    sel = 1;
    act = 0;
    wait_pin(0, 0, 40);
    // two sync flops plus the output flop: three edges
    `CHK(n, 3)
    repeat (200) @(negedge clk);
    `CHK(en_out, 1'b0)
    `CHK(rst_out_n, 1'b1)
    `CHK(barks, b0)
    act = 1;
    wait_pin(0, 1, RC + 20);
    `CHK(n >= RC && n <= RC + 6, 1'b1)
    wait_pin(1, 0, e + 20);
    `CHK(n >= e && n <= e + 4, 1'b1)
    give_verdict();
  end
endmodule : tb_wdg_top
